// [src/ingress_limiter_pkg.sv]
// Purpose: shared constants of the port ingress rate limiter
// Assumes: 50 MHz core clock, APB register access
// Notes: register indices are printed offsets; byte address is index times four
package ingress_limiter_pkg;

	// ************************************************************
	// register indices and fields
	// ************************************************************
	localparam logic [7:0] IDX_CTRL = 8'h03;
	localparam logic [7:0] IDX_LIM0 = 8'h10;
	localparam logic [7:0] IDX_LIM7 = 8'h17;
	localparam logic [7:0] IDX_STATUS = 8'h18;
	localparam int BIT_PORT = 6;
	localparam int BIT_PPS = 5;
	localparam int BIT_FC = 4;
	localparam int BIT_MODE_HI = 3;
	localparam int BIT_MODE_LO = 2;
	localparam int BIT_IFG = 1;
	localparam int BIT_PRE = 0;
	localparam logic [6:0] CTRL_RESET = 7'h00;
	localparam logic [6:0] LIMIT_RESET = 7'h00;

	typedef enum logic [1:0] {
		MODE_ALL = 2'b00,
		MODE_FLOOD = 2'b01,
		MODE_MULTI = 2'b10,
		MODE_BCAST = 2'b11
	} limit_mode_t;

	typedef enum logic [1:0] {
		SPEED_10 = 2'b00,
		SPEED_100 = 2'b01,
		SPEED_1000 = 2'b10
	} link_speed_t;

	// ************************************************************
	// per-frame overhead and rate codes
	// ************************************************************
	localparam logic [15:0] IFG_BYTES = 16'h000c;
	localparam logic [15:0] PRE_BYTES = 16'h0008;
	localparam logic [6:0] CODE_LINE = 7'h00;
	localparam logic [6:0] CODE_FINE_MAX = 7'h0a;
	localparam logic [6:0] CODE_COARSE_MAX = 7'h64;
	localparam logic [6:0] CODE_TABLE_BASE = 7'h64;
	localparam logic [6:0] CODE_TABLE_MAX = 7'h73;

	// ************************************************************
	// rates in packets or bits per second
	// ************************************************************
	localparam logic [31:0] RATE_UNLIMITED = 32'hffff_ffff;
	localparam logic [31:0] PPS_LINE_10 = 32'd19200;
	localparam logic [31:0] PPS_LINE_100 = 32'd192000;
	localparam logic [31:0] PPS_LINE_1000 = 32'd1920000;
	localparam logic [31:0] BPS_LINE_10 = 32'd10000000;
	localparam logic [31:0] BPS_LINE_100 = 32'd100000000;
	localparam logic [31:0] BPS_LINE_1000 = 32'd1000000000;
	localparam logic [31:0] PPS_STEP_LOW = 32'd1920;
	localparam logic [31:0] PPS_STEP_GIG = 32'd19200;
	localparam logic [31:0] BPS_STEP = 32'd1000000;
	localparam logic [31:0] BPS_STEP_GIG = 32'd10000000;
	localparam logic [31:0] PPS_TBL_FIRST = 32'd64;
	localparam logic [31:0] PPS_TBL_STEP = 32'd128;
	localparam logic [31:0] TBL_GIG_FACTOR = 32'd10;
	localparam logic [31:0] BPS_TBL_STEP = 32'd64000;
	localparam logic [31:0] BPS_TBL_FAST = 32'd640000;
	localparam logic [31:0] TBL_FAST_MAX = 32'd3;

	// ************************************************************
	// metering window
	// ************************************************************
	localparam int CLK_PERIOD_NS = 20;
	localparam int WINDOW_NS = 1000000000;
	localparam int WINDOW_CYCLES = WINDOW_NS / CLK_PERIOD_NS;

endpackage : ingress_limiter_pkg

// [src/port_ingress_rate_limiter.sv]
// Purpose: per-port ingress rate limiter with APB register access
// Assumes: frame descriptors come from ingress logic on pclk, one-cycle pulse
// Notes: metering counts units per one-second window, scaled by time_div
// Functional notes
// (RULE1) control bit 6 set: one port limit; clear: one limit per priority
// (RULE2) control bit 5 set: meter in frames; clear: meter in bits
// (RULE3) flow-control enable makes an exceeded rate assert flow control
// (RULE4) software must also enable port flow control before relying on it
// (RULE5) limit-mode field picks counted frames: all, flood, multi, broadcast only
// (RULE6) ifg bit adds twelve gap bytes per frame to the count
// (RULE7) preamble bit adds eight preamble bytes per frame to the count
// (RULE8) preamble bit ignored while counting frames
// (RULE9) priority 0 limit: 7-bit code, reset zero, top bit reads zero
// (RULE10) priority 0 code stays pending until priority 7 register is written
// (RULE11) code zero means full line rate at each link speed
// (RULE12) codes 1 to 10 give code times fixed step rates
// (RULE13) codes 11 to 100 give coarse rates; no packet limit at 10M
// (RULE14) codes 101 to 115 pick fixed low rates from a table
// (RULE15) control top bit reserved zero; other control bits reset zero
// (RULE16) priorities 1 to 7 limits alike; priority 7 write commits all
// (RULE17) port mode uses priority 0 code for every frame
`timescale 1ns/100ps
`default_nettype none
module port_ingress_rate_limiter
	import ingress_limiter_pkg::*;
#(
	parameter int window_cycles = WINDOW_CYCLES,
	parameter int time_div = 1
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] link_speed,
	input wire logic frame_valid,
	input wire logic [15:0] frame_len,
	input wire logic [2:0] frame_prio,
	input wire logic frame_bcast,
	input wire logic frame_mcast,
	input wire logic frame_flood,
	output logic verdict_valid,
	output logic verdict_drop,
	output logic flow_ctrl
);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic [6:0] ctrl;
		logic [7:0][6:0] pend;
		logic [7:0][6:0] act;
		logic [7:0][31:0] used;
		logic [7:0] exceeded;
		logic [31:0] timer;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic verdict_valid;
		logic verdict_drop;
		logic flow_ctrl;
	} state_t;

	localparam logic [31:0] WIN_LAST = 32'(window_cycles / time_div - 1);
	localparam logic [31:0] DIV = 32'(time_div);

	state_t st;
	state_t next_st;
	logic [7:0] idx;
	logic wr_ok;
	logic [2:0] bidx;
	logic [6:0] code;
	logic counted;
	logic wend;
	logic hit;
	logic pps;
	logic [31:0] cost;
	logic [31:0] budget;
	logic [31:0] used_sel;

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic [7:0] reg_index(input logic [11:0] addr);
		reg_index = addr[9:2];
	endfunction : reg_index

	function automatic logic is_limit(input logic [7:0] i);
		is_limit = (i >= IDX_LIM0) && (i <= IDX_LIM7);
	endfunction : is_limit

	function automatic logic [2:0] limit_slot(input logic [7:0] i);
		limit_slot = 3'(i - IDX_LIM0);
	endfunction : limit_slot

	function automatic logic [31:0] rate_of(
		input logic [6:0] c,
		input logic [1:0] speed,
		input logic by_pkt
	);
		logic [31:0] n;
		logic gig;
		logic ten;
		n = 32'(c);
		gig = (speed == SPEED_1000);
		ten = (speed == SPEED_10);
		rate_of = RATE_UNLIMITED;
		// (RULE11) full line rate
		if (c == CODE_LINE)
			rate_of = by_pkt ? (gig ? PPS_LINE_1000 : ten ? PPS_LINE_10 : PPS_LINE_100)
				: (gig ? BPS_LINE_1000 : ten ? BPS_LINE_10 : BPS_LINE_100);
		// (RULE12) fine steps
		else if (c <= CODE_FINE_MAX)
			rate_of = by_pkt ? n * (gig ? PPS_STEP_GIG : PPS_STEP_LOW) : n * BPS_STEP;
		// (RULE13) coarse steps
		else if (c <= CODE_COARSE_MAX)
		begin
			if (by_pkt)
				rate_of = ten ? RATE_UNLIMITED : n * (gig ? PPS_STEP_GIG : PPS_STEP_LOW);
			else
				rate_of = ten ? BPS_LINE_10 : n * (gig ? BPS_STEP_GIG : BPS_STEP);
		end
		// (RULE14) low-rate table
		else if (c <= CODE_TABLE_MAX)
		begin
			n = 32'(c - CODE_TABLE_BASE);
			if (by_pkt)
			begin
				rate_of = (n == 32'd1) ? PPS_TBL_FIRST : (n - 32'd1) * PPS_TBL_STEP;
				if (gig)
					rate_of = rate_of * TBL_GIG_FACTOR;
			end
			else if (gig || (!ten && n <= TBL_FAST_MAX))
				rate_of = n * BPS_TBL_FAST;
			else
				rate_of = n * BPS_TBL_STEP;
		end
	endfunction : rate_of

	// ************************************************************
	// next state
	// ************************************************************
	always_comb
	begin
		next_st = st;
		idx = reg_index(paddr);
		wr_ok = psel && penable && st.pready && pwrite && pstrb[0];
		pps = st.ctrl[BIT_PPS];
		// (RULE1) port or priority select
		// (RULE17) port mode reads bucket zero
		bidx = st.ctrl[BIT_PORT] ? 3'd0 : frame_prio;
		code = st.act[bidx];
		used_sel = st.used[bidx];
		// (RULE5) frame class filter
		case (limit_mode_t'(st.ctrl[BIT_MODE_HI:BIT_MODE_LO]))
			MODE_ALL: counted = 1'b1;
			MODE_FLOOD: counted = frame_bcast || frame_mcast || frame_flood;
			MODE_MULTI: counted = frame_bcast || frame_mcast;
			MODE_BCAST: counted = frame_bcast;
			default: counted = 1'b1;
		endcase
		// (RULE2) frame or bit cost
		// (RULE6) gap bytes
		// (RULE7) preamble bytes
		// (RULE8) preamble ignored in frame mode
		if (pps)
			cost = 32'd1;
		else
			cost = {13'd0, frame_len + (st.ctrl[BIT_IFG] ? IFG_BYTES : 16'd0)
				+ (st.ctrl[BIT_PRE] ? PRE_BYTES : 16'd0), 3'd0};
		budget = rate_of(code, link_speed, pps);
		if (budget != RATE_UNLIMITED)
			budget = budget / DIV;
		wend = (st.timer == WIN_LAST);
		hit = ({1'b0, wend ? 32'd0 : used_sel} + {1'b0, cost}) > {1'b0, budget};

		// apb answer registered in setup, ready in the first access-phase cycle
		next_st.pready = psel && !penable;
		if (psel && !penable)
		begin
			next_st.pslverr = 1'b0;
			next_st.prdata = 32'h0000_0000;
			if (idx == IDX_CTRL)
				// (RULE15) reserved top bit zero
				next_st.prdata = {25'd0, st.ctrl};
			else if (is_limit(idx))
				// (RULE9) reserved top bit zero
				next_st.prdata = {25'd0, st.pend[limit_slot(idx)]};
			else if (idx == IDX_STATUS)
				next_st.prdata = {24'd0, st.exceeded};
			else
				next_st.pslverr = 1'b1;
		end
		if (wr_ok)
		begin
			if (idx == IDX_CTRL)
				next_st.ctrl = pwdata[6:0];
			else if (is_limit(idx))
				// (RULE10) held pending
				next_st.pend[limit_slot(idx)] = pwdata[6:0];
			// (RULE16) priority 7 write commits all
			if (idx == IDX_LIM7)
				next_st.act = next_st.pend;
		end

		// metering window
		next_st.timer = wend ? 32'd0 : st.timer + 32'd1;
		if (wend)
		begin
			next_st.used = '0;
			next_st.exceeded = '0;
		end
		next_st.verdict_valid = frame_valid;
		next_st.verdict_drop = 1'b0;
		if (frame_valid && counted)
		begin
			if (hit)
			begin
				// a new excess wins over the window clear
				next_st.verdict_drop = 1'b1;
				next_st.exceeded[bidx] = 1'b1;
			end
			else
				next_st.used[bidx] = (wend ? 32'd0 : used_sel) + cost;
		end
		// (RULE3) flow control gated by enable
		// (RULE4) port pause must also be enabled by software
		next_st.flow_ctrl = st.ctrl[BIT_FC] && (|next_st.exceeded);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= '0;
			st.ctrl <= CTRL_RESET;
			st.pend <= {8{LIMIT_RESET}};
			st.act <= {8{LIMIT_RESET}};
		end
		else
			st <= next_st;
	end

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign verdict_valid = st.verdict_valid;
	assign verdict_drop = st.verdict_drop;
	assign flow_ctrl = st.flow_ctrl;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_wr_lim0;
		wr_ok && idx == IDX_LIM0;
	endsequence

	sequence s_wr_lim7;
		wr_ok && idx == IDX_LIM7;
	endsequence

	sequence s_setup_ctrl;
		psel && !penable && !pwrite && idx == IDX_CTRL;
	endsequence

	sequence s_setup_lim;
		psel && !penable && !pwrite && is_limit(idx);
	endsequence

	sequence s_wr_ctrl;
		wr_ok && idx == IDX_CTRL;
	endsequence

	chk_pending_hold: assert property (s_wr_lim0 |=> st.act == $past(st.act)) // RULE10
		else $error("priority 0 limit took effect without commit");

	chk_commit_all: assert property (s_wr_lim7 |=> st.act[7] == $past(pwdata[6:0]) // RULE16
		&& st.act[0] == $past(st.pend[0]))
		else $error("priority 7 write did not commit limits");

	chk_ctrl_readback: assert property (s_setup_ctrl |=> pready && !pslverr // RULE15
		&& prdata == {25'd0, st.ctrl})
		else $error("control readback wrong");

	chk_fc_gate: assert property (!st.ctrl[BIT_FC] |=> !flow_ctrl) // RULE3
		else $error("flow control without enable");

	chk_fc_raise: assert property (st.ctrl[BIT_FC] && frame_valid && counted && hit // RULE3
		&& !(wr_ok && idx == IDX_CTRL) |=> flow_ctrl && verdict_drop)
		else $error("exceeded rate did not raise flow control");

	chk_class_bcast: assert property (st.ctrl[BIT_MODE_HI:BIT_MODE_LO] == MODE_BCAST // RULE5
		&& frame_valid && !frame_bcast |=> verdict_valid && !verdict_drop)
		else $error("non-broadcast frame limited in broadcast mode");

	chk_pps_cost: assert property (pps && frame_valid && counted && !hit && !wend // RULE2
		|=> st.used[$past(bidx)] == $past(used_sel) + 32'd1)
		else $error("frame mode did not count one per frame");

	chk_ifg_cost: assert property (!pps && st.ctrl[BIT_IFG] && !st.ctrl[BIT_PRE] // RULE6
		&& frame_valid && counted && !hit && !wend
		|=> st.used[$past(bidx)] == $past(used_sel)
		+ {13'd0, $past(frame_len) + IFG_BYTES, 3'd0})
		else $error("gap bytes not added");

	chk_port_bucket: assert property (st.ctrl[BIT_PORT] && frame_valid && frame_prio != 3'd0 // RULE17
		&& !wend |=> st.used[$past(frame_prio)] == $past(st.used[frame_prio]))
		else $error("port mode touched a priority bucket");

	chk_zero_line: assert property (code == CODE_LINE && !pps // RULE11
		&& link_speed == SPEED_100 |-> budget == BPS_LINE_100 / DIV)
		else $error("code zero not line rate");

	chk_lim_readback: assert property (s_setup_lim |=> pready && !pslverr // RULE9
		&& prdata == {25'd0, $past(st.pend[limit_slot(idx)])})
		else $error("limit readback wrong");

	chk_ctrl_write: assert property (s_wr_ctrl |=> st.ctrl == $past(pwdata[6:0])) // RULE15
		else $error("control write not taken");

	chk_pre_cost: assert property (!pps && st.ctrl[BIT_PRE] && !st.ctrl[BIT_IFG] // RULE7
		&& frame_valid && counted && !hit && !wend
		|=> st.used[$past(bidx)] == $past(used_sel)
		+ {13'd0, $past(frame_len) + PRE_BYTES, 3'd0})
		else $error("preamble bytes not added");

	chk_pre_ignored: assert property (pps && st.ctrl[BIT_PRE] // RULE8
		&& frame_valid && counted && !hit && !wend
		|=> st.used[$past(bidx)] == $past(used_sel) + 32'd1)
		else $error("preamble counted in frame mode");

	chk_fine_rate: assert property (code != CODE_LINE && code <= CODE_FINE_MAX && !pps // RULE12
		|-> budget == (32'(code) * BPS_STEP) / DIV)
		else $error("fine code bit rate wrong");

	chk_packet_free: assert property (pps && link_speed == SPEED_10 && frame_valid // RULE13
		&& code > CODE_FINE_MAX && code <= CODE_COARSE_MAX |=> verdict_valid && !verdict_drop)
		else $error("packet limit applied at ten megabit");

endmodule : port_ingress_rate_limiter
`default_nettype wire

// [sim/port_ingress_rate_limiter_test.sv]
// Purpose: self-checking bench for the port ingress rate limiter
// Assumes: time_div of 1000, so a metering window is 50000 cycles
// Notes: each metering case starts from a fresh reset so every bucket starts empty
`timescale 1ns/100ps
`default_nettype none
module port_ingress_rate_limiter_test
	import ingress_limiter_pkg::*;
;
	// ****************************************
	// signals and shared tasks
	// ****************************************
	localparam int TDIV = 1000;
	logic pclk, presetn, psel, penable, pwrite, frame_valid, frame_bcast, frame_mcast, frame_flood;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	logic [1:0] link_speed;
	logic [15:0] frame_len;
	logic [2:0] frame_prio;
	logic pready, pslverr, verdict_valid, verdict_drop, flow_ctrl;
	int n_fail = 0;
	int checks_done = 0;

	port_ingress_rate_limiter #(.time_div(TDIV)) port_ingress_rate_limiter_i (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link_speed(link_speed),
		.frame_valid(frame_valid), .frame_len(frame_len), .frame_prio(frame_prio), .frame_bcast(frame_bcast),
		.frame_mcast(frame_mcast), .frame_flood(frame_flood), .verdict_valid(verdict_valid),
		.verdict_drop(verdict_drop), .flow_ctrl(flow_ctrl));

	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done

	task automatic cmp_flag(input logic got, input logic exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: %s is %b", $time, what, got);
		end
	endtask : cmp_flag

	task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: read %h, wanted %h", $time, got, exp);
		end
	endtask : cmp_data

	// holds the request until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd, input logic [3:0] st,
		output logic [31:0] rd, output logic err);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= wd;
		pstrb <= st;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do
		begin
			@(posedge pclk);
			i++;
		end
		while (pready !== 1'b1 && i < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			n_fail++;
			$display("unexpected at %0t: no pready", $time);
			test_done();
		end
	endtask : apb

	task automatic wreg(input logic [7:0] idx, input logic [31:0] v);
		logic [31:0] rd;
		logic err;
		apb(1'b1, idx, v, 4'hf, rd, err);
	endtask : wreg

	task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
		logic [31:0] rd;
		logic err;
		apb(1'b0, idx, 32'h0000_0000, 4'h0, rd, err);
		cmp_data(rd, exp);
		cmp_flag(err, 1'b0, "pslverr");
	endtask : rchk

	task automatic send(input int len, input int p, input int cls, input logic drop, input logic fc);
		@(posedge pclk);
		frame_valid <= 1'b1;
		frame_len <= 16'(len);
		frame_prio <= 3'(p);
		frame_flood <= (cls == 1);
		frame_mcast <= (cls == 2);
		frame_bcast <= (cls == 3);
		@(posedge pclk);
		frame_valid <= 1'b0;
		#1;
		cmp_flag(verdict_valid, 1'b1, "verdict_valid");
		cmp_flag(verdict_drop, drop, "verdict_drop");
		cmp_flag(flow_ctrl, fc, "flow_ctrl");
	endtask : send

	// rate per second from the code table; -1 means no limit
	function automatic longint rate(input int c, input int s, input bit pkt);
		longint pps;
		longint g;
		pps = (s == 2) ? 19200 : 1920;
		g = (s == 2) ? 10 : 1;
		if (c == 0)
			return pkt ? 19200 * (10 ** s) : 10000000 * (10 ** s);
		if (c <= 10)
			return pkt ? pps * c : 1000000 * c;
		if (c <= 100)
			return pkt ? ((s == 0) ? -1 : pps * c) : ((s == 0) ? 10000000 : 1000000 * c * g);
		if (c <= 115)
			return pkt ? ((c == 101) ? 64 : 128 * (c - 101)) * g
				: ((s == 0 || (s == 1 && c > 103)) ? 64000 : 640000) * (c - 100);
		return -1;
	endfunction : rate

	// fresh reset, program, then fill the bucket to the frame that must drop, or send four passing frames when no limit applies
	task automatic run_case(input logic [6:0] ctrl, input int code, input int spd, input int len, input int cls);
		int p;
		int n;
		longint bud;
		longint cost;
		bit lim;
		@(posedge pclk);
		presetn <= 1'b0;
		link_speed <= 2'(spd);
		@(posedge pclk);
		presetn <= 1'b1;
		p = $urandom_range(7, 0);
		wreg(IDX_CTRL, {25'h0, ctrl});
		for (int i = 0; i < 8; i++)
			wreg(IDX_LIM0 + 8'(i), ((ctrl[BIT_PORT] ? i == 0 : i == p) ? code : 0));
		bud = rate(code, spd, ctrl[BIT_PPS]);
		cost = ctrl[BIT_PPS] ? 1 : (len + (ctrl[BIT_IFG] ? 12 : 0) + (ctrl[BIT_PRE] ? 8 : 0)) * 8;
		lim = (bud >= 0) && (cls >= ctrl[BIT_MODE_HI:BIT_MODE_LO]);
		n = lim ? int'(bud / TDIV / cost) : 3;
		for (int i = 0; i <= n; i++)
			send(len, p, cls, lim && i == n, lim && i == n && ctrl[BIT_FC]);
		rchk(IDX_STATUS, lim ? (32'h0000_0001 << (ctrl[BIT_PORT] ? 0 : p)) : 32'h0000_0000);
	endtask : run_case

	// ****************************************
	// scenarios
	// ****************************************
	initial
	begin
		int seed;
		{psel, penable, pwrite, frame_valid, frame_bcast, frame_mcast, frame_flood} = '0;
		presetn = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		pstrb = 4'h0;
		link_speed = 2'b00;
		frame_len = 16'h0000;
		frame_prio = 3'h0;
		seed = $urandom(32'h4695);
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rchk(IDX_CTRL, 32'h0000_0000);
		for (int i = 0; i < 8; i++)
			rchk(IDX_LIM0 + 8'(i), 32'h0000_0000);
		wreg(IDX_CTRL, 32'h0000_00ff);
		rchk(IDX_CTRL, 32'h0000_007f);
		begin
			logic [31:0] rd;
			logic err;
			apb(1'b1, IDX_CTRL, 32'h0000_0000, 4'he, rd, err);
			rchk(IDX_CTRL, 32'h0000_007f);
			apb(1'b0, 8'h20, 32'h0000_0000, 4'h0, rd, err);
			cmp_flag(err, 1'b1, "pslverr");
			cmp_data(rd, 32'h0000_0000);
		end
		wreg(IDX_CTRL, 32'h0000_0040);
		wreg(IDX_LIM0, 32'h0000_00e5);
		rchk(IDX_LIM0, 32'h0000_0065);
		for (int i = 0; i < 3; i++)
			send(8, i, 0, 1'b0, 1'b0);
		for (int m = 0; m < 4; m++)
			for (int k = 0; k < 4; k++)
				run_case({3'b100, 2'(m), 2'b00}, 101, 0, 8, k);
		run_case(7'h40, 1, 1, 113, 0);
		run_case(7'h42, 1, 1, 113, 0);
		// port flow control taken as enabled outside this block
		run_case(7'h53, 1, 1, 113, 0);
		run_case(7'h41, 1, 1, 117, 0);
		run_case(7'h71, 10, 2, 1500, 0);
		run_case(7'h50, 11, 0, 1375, 0);
		run_case(7'h40, 11, 1, 1375, 0);
		run_case(7'h40, 12, 2, 1500, 0);
		run_case(7'h70, 11, 0, 64, 0);
		run_case(7'h40, 115, 0, 120, 0);
		run_case(7'h40, 103, 1, 100, 0);
		run_case(7'h40, 0, 0, 125, 0);
		run_case(7'h60, 0, 2, 64, 0);
		run_case(7'h10, 101, 0, 8, 0);
		repeat (12)
			run_case({1'($urandom), 1'b0, 1'($urandom), 2'b00, 2'($urandom)}, $urandom_range(10, 1),
				$urandom_range(2, 0), $urandom_range(1500, 64), 0);
		test_done();
	end

	initial
	begin
		#(20 * 100000);
		n_fail++;
		$display("unexpected at %0t: run did not finish", $time);
		test_done();
	end
endmodule : port_ingress_rate_limiter_test
`default_nettype wire
